// ==== fcsp_pkg.sv ====
// Constants for the filter control serial port
// Function
// - Select high: gain and cutoff from pins
// - Select low: settings only from latch
// - Shift SDI on SCLK rise, MSB first
// - SDO updates on SCLK falling edges
// - Chip select rise loads latch in parallel
// - Shift clock gated while select high
// - SDO always driven, keeps last value
// - D7 gain LSB, D6 gain MSB
// - D5 cutoff LSB, D4 cutoff MSB
// - D1 set means shutdown in serial
// - D0 drives shared gain LSB pin
// - Shared pin direction follows select input
// - Gain code 00/01/10/11 gives 0/6/12/24dB
// - Cutoff code 00, 01 x4, 1x x16
// - Serial mode pins: select, clock, unused
package fcsp_pkg;
  localparam int         SHIFT_W     = 8;
  localparam int         GAIN_LSB_B  = 7;
  localparam int         GAIN_MSB_B  = 6;
  localparam int         CUT_LSB_B   = 5;
  localparam int         CUT_MSB_B   = 4;
  localparam int         PWR_DOWN_B  = 1;
  localparam int         GP_OUT_B    = 0;
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [1:0] GAIN_0DB    = 2'h0;
  localparam logic [1:0] GAIN_6DB    = 2'h1;
  localparam logic [1:0] GAIN_12DB   = 2'h2;
  localparam logic [1:0] GAIN_24DB   = 2'h3;
  localparam logic [1:0] CUT_X1      = 2'h0;
  localparam logic [1:0] CUT_X4      = 2'h1;
  localparam logic [1:0] CUT_X16     = 2'h2;
endpackage

// ==== fcsp_top.sv ====
// Serial and pin control front end of the filter
`timescale 1ns/100ps
`default_nettype none
module fcsp_top
  import fcsp_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       interface_select_n,
  input  wire logic       gain_code_msb,
  input  wire logic       gain_lsb_or_gp_out_pin_i,
  output logic            gain_lsb_or_gp_out_pin_o,
  output logic            gain_lsb_or_gp_out_pin_oe_n,
  input  wire logic       cutoff_msb_or_select_pin,
  input  wire logic       cutoff_lsb_or_serial_clock_pin,
  input  wire logic       sdi,
  output logic            sdo,
  output logic [1:0]      gain_code,
  output logic [1:0]      cutoff_code,
  output logic [1:0]      bandwidth_scale,
  output logic [4:0]      gain_db,
  output logic            power_down_bit
);
  import fcsp_pkg::*;

  // Two-flop synchronisers for every pin
  logic [5:0] s1, s2;
  always_ff @(posedge mclk)
  begin
    s1 <= {interface_select_n, gain_code_msb, gain_lsb_or_gp_out_pin_i,
           cutoff_msb_or_select_pin, cutoff_lsb_or_serial_clock_pin, sdi};
    s2 <= s1;
  end
  logic sel_n, g_msb, g_lsb, cs_n, sck, din;
  assign {sel_n, g_msb, g_lsb, cs_n, sck, din} = s2;

  // Edge history rests at the idle levels, so leaving reset makes no false edge
  logic sck_d, cs_d;
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sck_d <= 1'b0;
      cs_d  <= 1'b1;
    end
    else
    begin
      sck_d <= sck;
      cs_d  <= cs_n;
    end
  end
  // Edges are only honoured while selected, so idle clocks are gated
  logic sck_rise, sck_fall, cs_rise, serial;
  assign serial   = !sel_n;
  assign sck_rise = serial && !cs_n && sck && !sck_d;
  assign sck_fall = serial && !cs_n && !sck && sck_d;
  assign cs_rise  = serial && cs_n && !cs_d;

  logic [SHIFT_W-1:0] shreg;
  always_ff @(posedge mclk)
  begin
    if (rst)
      shreg <= '0;
    else if (sck_rise)
      shreg <= {shreg[SHIFT_W-2:0], din};
  end

  // SDO is never released; it holds across select high
  always_ff @(posedge mclk)
  begin
    if (rst)
      sdo <= 1'b0;
    else if (sck_fall)
      sdo <= shreg[SHIFT_W-1];
  end

  logic [SHIFT_W-1:0] filter_control_word;
  always_ff @(posedge mclk)
  begin
    if (rst)
      filter_control_word <= CTRL_RESET;
    else if (cs_rise)
      filter_control_word <= shreg;
  end

  // Pin mode drives the shared pin as input; serial mode drives D0
  assign gain_lsb_or_gp_out_pin_oe_n = sel_n;
  always_ff @(posedge mclk)
  begin
    if (rst)
      gain_lsb_or_gp_out_pin_o <= 1'b0;
    else
      gain_lsb_or_gp_out_pin_o <= filter_control_word[GP_OUT_B];
  end

  logic [1:0] next_gain, next_cut;
  logic       next_pd;
  always_comb
  begin
    if (sel_n)
    begin
      next_gain = {g_msb, g_lsb};
      next_cut  = {cs_n, sck};
      next_pd   = 1'b0;
    end
    else
    begin
      next_gain = {filter_control_word[GAIN_MSB_B], filter_control_word[GAIN_LSB_B]};
      next_cut  = {filter_control_word[CUT_MSB_B], filter_control_word[CUT_LSB_B]};
      next_pd   = filter_control_word[PWR_DOWN_B];
    end
  end

  function automatic logic [4:0] gain_to_db(input logic [1:0] c);
    unique case (c)
      GAIN_0DB:  gain_to_db = 5'h00;
      GAIN_6DB:  gain_to_db = 5'h06;
      GAIN_12DB: gain_to_db = 5'h0c;
      GAIN_24DB: gain_to_db = 5'h18;
    endcase
  endfunction

  function automatic logic [1:0] cut_to_scale(input logic [1:0] c);
    cut_to_scale = c[1] ? CUT_X16 : (c[0] ? CUT_X4 : CUT_X1);
  endfunction

  // Settings are registered so pin glitches never reach the filter directly
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      gain_code       <= 2'h0;
      cutoff_code     <= 2'h0;
      power_down_bit  <= 1'b0;
      gain_db         <= 5'h00;
      bandwidth_scale <= CUT_X1;
    end
    else
    begin
      gain_code       <= next_gain;
      cutoff_code     <= next_cut;
      power_down_bit  <= next_pd;
      gain_db         <= gain_to_db(next_gain);
      bandwidth_scale <= cut_to_scale(next_cut);
    end
  end

  // Shift path, latch and mode checks
  property p_shift;
    @(posedge mclk) disable iff (rst) sck_rise |=> shreg[0] == $past(din);
  endproperty
  a_shift: assert property (p_shift) else $error("shift lost bit");
  property p_sdo;
    @(posedge mclk) disable iff (rst) sck_fall |=> sdo == $past(shreg[SHIFT_W-1]);
  endproperty
  a_sdo: assert property (p_sdo) else $error("sdo wrong");
  property p_load;
    @(posedge mclk) disable iff (rst) cs_rise |=> filter_control_word == $past(shreg);
  endproperty
  a_load: assert property (p_load) else $error("latch not loaded");
  property p_gate;
    @(posedge mclk) disable iff (rst) cs_n && cs_d |=> $stable(shreg) && $stable(filter_control_word);
  endproperty
  a_gate: assert property (p_gate) else $error("activity while deselected");
  property p_sdo_hold;
    @(posedge mclk) disable iff (rst) cs_n |=> $stable(sdo);
  endproperty
  a_sdo_hold: assert property (p_sdo_hold) else $error("sdo changed deselected");
  property p_pin;
    @(posedge mclk) disable iff (rst) sel_n |=> gain_code == $past({g_msb, g_lsb}) && !power_down_bit;
  endproperty
  a_pin: assert property (p_pin) else $error("pin mode gain wrong");
  property p_ser;
    @(posedge mclk) disable iff (rst) !sel_n |=> power_down_bit == $past(filter_control_word[PWR_DOWN_B]);
  endproperty
  a_ser: assert property (p_ser) else $error("shutdown wrong");
  property p_dir;
    @(posedge mclk) disable iff (rst) gain_lsb_or_gp_out_pin_oe_n == sel_n;
  endproperty
  a_dir: assert property (p_dir) else $error("pin direction wrong");
  property p_db;
    @(posedge mclk) disable iff (rst) gain_code == GAIN_24DB |-> gain_db == 5'h18;
  endproperty
  a_db: assert property (p_db) else $error("gain db wrong");

  // Serial mode settings follow the latch fields one cycle later
  property p_gain_ser;
    @(posedge mclk) disable iff (rst)
      !sel_n |=> gain_code == $past({filter_control_word[GAIN_MSB_B], filter_control_word[GAIN_LSB_B]});
  endproperty
  a_gain_ser: assert property (p_gain_ser) else $error("serial gain wrong");
  property p_cut_ser;
    @(posedge mclk) disable iff (rst)
      !sel_n |=> cutoff_code == $past({filter_control_word[CUT_MSB_B], filter_control_word[CUT_LSB_B]});
  endproperty
  a_cut_ser: assert property (p_cut_ser) else $error("serial cutoff wrong");
  property p_gp_out;
    @(posedge mclk) disable iff (rst)
      !sel_n |=> gain_lsb_or_gp_out_pin_o == $past(filter_control_word[GP_OUT_B]);
  endproperty
  a_gp_out: assert property (p_gp_out) else $error("general output wrong");

  // Pin mode takes the cutoff pins as levels and leaves the serial state alone
  property p_cut_pin;
    @(posedge mclk) disable iff (rst) sel_n |=> cutoff_code == $past({cs_n, sck});
  endproperty
  a_cut_pin: assert property (p_cut_pin) else $error("pin mode cutoff wrong");
  property p_pin_gate;
    @(posedge mclk) disable iff (rst) sel_n |=> $stable(shreg) && $stable(filter_control_word);
  endproperty
  a_pin_gate: assert property (p_pin_gate) else $error("serial state moved in pin mode");
  property p_bw;
    @(posedge mclk) disable iff (rst) cutoff_code[1] |-> bandwidth_scale == CUT_X16;
  endproperty
  a_bw: assert property (p_bw) else $error("bandwidth scale wrong");

  // Main scenarios: load, shutdown, mode change, widest band, high bit out
  c_load: cover property (@(posedge mclk) disable iff (rst) cs_rise);
  c_power_down_bit: cover property (@(posedge mclk) disable iff (rst) power_down_bit);
  c_pin:  cover property (@(posedge mclk) disable iff (rst) !sel_n ##1 sel_n);
  c_wide: cover property (@(posedge mclk) disable iff (rst) bandwidth_scale == CUT_X16);
  c_sdo:  cover property (@(posedge mclk) disable iff (rst) sck_fall && shreg[SHIFT_W-1]);
endmodule
`default_nettype wire

// ==== fcsp_spi_ctrl.sv ====
// SPI controller model on the far side of the serial port
`timescale 1ns/100ps
`default_nettype none
module fcsp_spi_ctrl
(
  input  wire logic mclk,
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi
);
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // Clock parked low before select falls; one select rise ends the whole chain
  task automatic send(input logic [15:0] w, input int n, input int hp);
    sclk <= 1'b0;
    repeat (hp) @(posedge mclk);
    cs_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      mosi <= w[i];
      repeat (hp) @(posedge mclk);
      sclk <= 1'b1;
      repeat (hp) @(posedge mclk);
      sclk <= 1'b0;
    end
    repeat (hp) @(posedge mclk);
    cs_n <= 1'b1;
    // Released data line does not keep its last bit
    mosi <= ~w[0];
    repeat (hp) @(posedge mclk);
  endtask
  // Clock pulses with select high, which the port must ignore
  task automatic stray(input int n);
    repeat (n)
    begin
      mosi  <= ~mosi;
      sclk  <= 1'b1;
      repeat (4) @(posedge mclk);
      sclk  <= 1'b0;
      repeat (4) @(posedge mclk);
    end
  endtask
endmodule
`default_nettype wire

// ==== fcsp_top_tb.sv ====
// Self-checking bench for the filter control serial port
`timescale 1ns/100ps
`default_nettype none
module fcsp_top_tb;
  import fcsp_pkg::*;
  logic        mclk, rst, sel_n, gmsb, glsb, sclk, cs_n, mosi, go, oen, sdo, pd;
  logic [1:0]  cpin, gc, cc, bw;
  logic [4:0]  db;
  logic [7:0]  w, v;
  logic [15:0] cap;
  int          n_errors, checks_done, seed, i;
  wire logic   gpin;
  assign gpin = oen ? glsb : go;
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  fcsp_top fcsp_top_inst (.mclk(mclk), .rst(rst), .interface_select_n(sel_n), .gain_code_msb(gmsb),
    .gain_lsb_or_gp_out_pin_i(gpin), .gain_lsb_or_gp_out_pin_o(go), .gain_lsb_or_gp_out_pin_oe_n(oen),
    .cutoff_msb_or_select_pin(sel_n ? cpin[1] : cs_n), .cutoff_lsb_or_serial_clock_pin(sel_n ? cpin[0] : sclk),
    .sdi(mosi), .sdo(sdo), .gain_code(gc), .cutoff_code(cc), .bandwidth_scale(bw), .gain_db(db),
    .power_down_bit(pd));
  fcsp_spi_ctrl fcsp_spi_ctrl_inst (.mclk(mclk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi));
  function automatic logic [12:0] ex(logic [1:0] g, logic [1:0] c, logic p, logic o);
    logic [4:0] d;
    d = (g == 2'h0) ? 5'h00 : (g == 2'h1) ? 5'h06 : (g == 2'h2) ? 5'h0c : 5'h18;
    return {g, c, c[1] ? CUT_X16 : c, d, p, o};
  endfunction
  task automatic chk(logic [12:0] g, logic [12:0] e);
    checks_done++;
    if (g !== e)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_ser(logic [7:0] x);
    repeat (6) @(posedge mclk);
    chk({gc, cc, bw, db, pd, oen}, ex({x[6], x[7]}, {x[4], x[5]}, x[1], 1'b0));
    chk({12'h000, go}, {12'h000, x[0]});
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge sclk) cap <= {cap[14:0], sdo};
  initial
  begin
    repeat (20000) @(posedge mclk);
    $display("mismatch at %0t: timeout", $time);
    n_errors++;
    finish_test;
  end
  initial
  begin
    {rst, sel_n, gmsb, glsb, cpin, n_errors, checks_done} = {1'b1, 5'h00, 64'h0};
    seed = 32'hda42;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    chk_ser(CTRL_RESET);
    $display("test reset done");
    for (i = 0; i < 12; i++)
    begin
      w = 8'($random(seed));
      if (i < 4) w[7:4] = {i[0], i[1], i[1], i[0]};
      if (i == 4) w = 8'hff;
      gmsb <= w[2];
      fcsp_spi_ctrl_inst.send({8'h00, w}, 8, 4);
      chk_ser(w);
    end
    fcsp_spi_ctrl_inst.stray(5);
    chk_ser(w);
    chk({12'h000, sdo}, {12'h000, w[7]});
    $display("test serial done");
    v = 8'($random(seed));
    w = 8'($random(seed));
    fcsp_spi_ctrl_inst.send({v, w}, 16, 4);
    chk({5'h00, cap[7:0]}, {5'h00, v});
    chk_ser(w);
    chk({12'h000, sdo}, {12'h000, w[7]});
    $display("test chain done");
    sel_n <= 1'b1;
    for (i = 0; i < 4; i++)
    begin
      {gmsb, glsb} <= i[1:0];
      cpin <= ~i[1:0];
      repeat (8) @(posedge mclk);
      chk({gc, cc, bw, db, pd, oen}, ex(i[1:0], ~i[1:0], 1'b0, 1'b1));
    end
    $display("test pins done");
    finish_test;
  end
endmodule
`default_nettype wire
